// ---- nb_periph_model.sv ----
// Byte-wide peripheral device model standing on the far side of the bridge
`timescale 1ns/10ps
`default_nettype none
module nb_periph_model (
  // Clock and byte bus
  input wire logic clk,
  input wire logic nb_rd,
  input wire logic nb_wr,
  input wire logic [16:0] nb_addr,
  input wire logic [7:0] nb_wdata,
  input wire logic [1:0] wait_cycles,
  output logic nb_ack,
  output logic [7:0] nb_rdata
);
  logic [7:0] mem [int];
  int cnt = 0;
  initial begin
    nb_ack = 1'b0;
    nb_rdata = 8'h00;
  end
  // One ack per strobe after a chosen wait; idle data toggles so stale bytes never look valid
  always @(posedge clk) begin
    if ((nb_rd || nb_wr) && !nb_ack && cnt >= wait_cycles) begin
      nb_ack <= 1'b1;
      if (nb_wr) mem[nb_addr] = nb_wdata;
      nb_rdata <= mem.exists(nb_addr) ? mem[nb_addr] : nb_addr[7:0] ^ 8'h5A;
    end else begin
      nb_ack <= 1'b0;
      nb_rdata <= ~nb_rdata;
    end
    cnt = nb_ack ? 0 : cnt + ((nb_rd || nb_wr) ? 1 : 0);
  end
endmodule // nb_periph_model
`default_nettype wire

// ---- nbus_bridge_pkg.sv ----
// Constants shared by the PCI-to-peripheral byte bus bridge
`default_nettype none
package nbus_bridge_pkg;
  // Claimed window of PCI I/O space (lowest 64K)
  localparam logic [31:0] IO_WINDOW_SIZE = 32'h0001_0000;
  // Contiguous-byte time-of-year clock window inside the I/O window
  localparam logic [31:0] TIME_OF_YEAR_CLOCK_BASE = 32'h0000_7000;
  localparam logic [31:0] TIME_OF_YEAR_CLOCK_SIZE = 32'h0000_0100;
  // Contiguous-byte ROM window in PCI memory space
  localparam logic [31:0] ROM_MEM_BASE = 32'h000E_0000;
  localparam logic [31:0] ROM_MEM_SIZE = 32'h0002_0000;
  // Sparse processor view: one peripheral byte per 32-byte step
  localparam int SPARSE_SHIFT = 5;
  localparam logic [31:0] SPARSE_IO_BASE = 32'h0000_0000;
  // Recovery field: bit 3 enables, bits 2:0 give extra system ticks
  localparam int RECOVERY_EN_BIT = 3;
  localparam logic [3:0] RECOVERY_RESET = 4'h9;
  // Clock rate and default system-clock tick length
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYS_TICK_NS = 8;
  localparam int SYS_TICK_CYCLES = (SYS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bridge sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_RECOVER = 3'b100
  } bridge_state_t;
endpackage
`default_nettype wire

// ---- pci_sparse_io_byte_bus_bridge.sv ----
// Bridge from upstream single-byte PCI accesses to the local byte-wide peripheral bus
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RULE_01] Claim lowest 64K I/O, forward every access (the code forwards only single bytes in an accepted lane and refuses the rest)
// [RULE_02] Only single-byte transfers reach the peripheral bus
// [RULE_03] Byte register sits in longword lane zero
// [RULE_04] Clock and ROM regions use contiguous bytes
// [RULE_05] Requester asserts exactly one byte enable
// [RULE_06] No base registers; claim by subtractive decode
// [RULE_07] Recovery field inserts ticks between cycles
// [RULE_08] Boot ROM left without positive decode
// [RULE_09] Sparse address is base plus offset shl five
module pci_sparse_io_byte_bus_bridge
  import nbus_bridge_pkg::*;
#(
  parameter int NB_ADDR_W = 17,
  parameter int TICK_CYCLES = SYS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Upstream request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_mem_space,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_byte_en,
  input wire logic req_write,
  input wire logic [31:0] req_wdata,
  input wire logic req_pos_claimed,
  // Upstream answer
  output logic rsp_valid,
  output logic rsp_claimed,
  output logic rsp_error,
  output logic [31:0] rsp_rdata,
  // Peripheral byte bus
  output logic [NB_ADDR_W-1:0] nb_addr,
  output logic [7:0] nb_wdata,
  output logic nb_rd,
  output logic nb_wr,
  output logic nb_rom_cycle,
  input wire logic [7:0] nb_rdata,
  input wire logic nb_ack,
  // Control and observation
  input wire logic [3:0] recovery_field,
  output logic [31:0] last_sparse_addr
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  bridge_state_t state_reg;
  logic req_ready_reg;
  logic rsp_valid_reg;
  logic rsp_claimed_reg;
  logic rsp_error_reg;
  logic [31:0] rsp_rdata_reg;
  logic [NB_ADDR_W-1:0] nb_addr_reg;
  logic [7:0] nb_wdata_reg;
  logic nb_rd_reg;
  logic nb_wr_reg;
  logic nb_rom_cycle_reg;
  logic [1:0] lane_reg;
  logic [15:0] recover_cnt_reg;
  logic [31:0] last_sparse_addr_reg;

  logic take;
  logic in_io_window;
  logic in_time_of_year_clock;
  logic in_rom;
  logic claim;
  logic single_lane;
  logic [1:0] lane;
  logic lane_ok;
  logic [NB_ADDR_W-1:0] nb_addr_next;
  logic [15:0] recover_next;

  // Exactly one enable set; anything else is not a byte transfer
  function automatic logic one_hot4(input logic [3:0] v);
    return (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
  endfunction

  // Lane number of a single enable
  function automatic logic [1:0] lane_of(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[1]) begin
      r = 2'h1;
    end else if (v[2]) begin
      r = 2'h2;
    end else if (v[3]) begin
      r = 2'h3;
    end
    return r;
  endfunction

  // Half-open window test
  function automatic logic in_window(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    return (a >= base) && ((a - base) < size);
  endfunction

  // Reset released through two flops, asserted at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Address decode; claims only what no other agent took
  always_comb begin
    in_io_window = !req_mem_space && (req_addr < IO_WINDOW_SIZE); // RULE_01
    in_time_of_year_clock = in_io_window && in_window(req_addr, TIME_OF_YEAR_CLOCK_BASE, TIME_OF_YEAR_CLOCK_SIZE);
    in_rom = req_mem_space && in_window(req_addr, ROM_MEM_BASE, ROM_MEM_SIZE);
    // Subtractive: fixed regions taken only when nobody else answered
    claim = (in_io_window || in_rom) && !req_pos_claimed; // RULE_06 RULE_08
    single_lane = one_hot4(req_byte_en); // RULE_02 RULE_05
    lane = lane_of(req_byte_en);
    // Longword regions accept only the low lane
    lane_ok = single_lane && (in_time_of_year_clock || in_rom || (lane == 2'h0)); // RULE_03
    if (in_rom) begin
      nb_addr_next = NB_ADDR_W'((req_addr - ROM_MEM_BASE) & 32'hFFFF_FFFC) | NB_ADDR_W'(lane); // RULE_04
    end else if (in_time_of_year_clock) begin
      nb_addr_next = NB_ADDR_W'({req_addr[15:2], lane}); // RULE_04
    end else begin
      nb_addr_next = NB_ADDR_W'(req_addr[15:2]); // RULE_03
    end
  end

  assign take = req_valid && req_ready_reg;

  // Extra ticks only when the enable bit of the field is set
  always_comb begin
    if (recovery_field[RECOVERY_EN_BIT]) begin
      recover_next = 16'(recovery_field[2:0]) * 16'(TICK_CYCLES); // RULE_07
    end else begin
      recover_next = 16'h0000;
    end
  end

  // Sequencer: one byte cycle, then recovery when the field gives extra ticks, then ready again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      req_ready_reg <= 1'b0;
      recover_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          req_ready_reg <= 1'b1;
          if (take && claim && lane_ok) begin
            state_reg <= ST_ACCESS;
            req_ready_reg <= 1'b0;
          end
        end
        ST_ACCESS: begin
          if (nb_ack) begin
            if (recover_next == 16'h0000) begin
              state_reg <= ST_IDLE;
              req_ready_reg <= 1'b1;
            end else begin
              state_reg <= ST_RECOVER; // RULE_07
              recover_cnt_reg <= recover_next;
            end
          end
        end
        ST_RECOVER: begin
          // Back-to-back cycles held off until the count runs out
          recover_cnt_reg <= recover_cnt_reg - 16'h0001; // RULE_07
          if (recover_cnt_reg == 16'h0001) begin
            state_reg <= ST_IDLE;
            req_ready_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          req_ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // Peripheral strobes held from launch until acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nb_addr_reg <= '0;
      nb_wdata_reg <= 8'h00;
      nb_rd_reg <= 1'b0;
      nb_wr_reg <= 1'b0;
      nb_rom_cycle_reg <= 1'b0;
      lane_reg <= 2'h0;
    end else if (state_reg == ST_IDLE && take && claim && lane_ok) begin
      nb_addr_reg <= nb_addr_next;
      nb_wdata_reg <= req_wdata[8*lane +: 8]; // RULE_02
      nb_rd_reg <= !req_write;
      nb_wr_reg <= req_write;
      nb_rom_cycle_reg <= in_rom;
      lane_reg <= lane;
    end else if (state_reg == ST_ACCESS && nb_ack) begin
      nb_rd_reg <= 1'b0;
      nb_wr_reg <= 1'b0;
    end
  end

  // Answer: one-cycle pulse, read byte placed in its own lane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_claimed_reg <= 1'b0;
      rsp_error_reg <= 1'b0;
      rsp_rdata_reg <= 32'h0000_0000;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (state_reg == ST_IDLE && take && !(claim && lane_ok)) begin
        // Unclaimed passes on; claimed but not a single byte in an accepted lane is refused
        rsp_valid_reg <= 1'b1;
        rsp_claimed_reg <= claim;
        rsp_error_reg <= claim; // RULE_02
        rsp_rdata_reg <= 32'h0000_0000;
      end else if (state_reg == ST_ACCESS && nb_ack) begin
        rsp_valid_reg <= 1'b1;
        rsp_claimed_reg <= 1'b1;
        rsp_error_reg <= 1'b0;
        rsp_rdata_reg <= nb_rd_reg ? (32'(nb_rdata) << {lane_reg, 3'b000}) : 32'h0000_0000;
      end
    end
  end

  // Processor-side sparse address of the last forwarded I/O byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_sparse_addr_reg <= 32'h0000_0000;
    end else if (state_reg == ST_IDLE && take && claim && lane_ok && !in_rom) begin
      last_sparse_addr_reg <= SPARSE_IO_BASE + (32'(req_addr[15:0]) << SPARSE_SHIFT); // RULE_09
    end
  end

  assign req_ready = req_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_claimed = rsp_claimed_reg;
  assign rsp_error = rsp_error_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign nb_addr = nb_addr_reg;
  assign nb_wdata = nb_wdata_reg;
  assign nb_rd = nb_rd_reg;
  assign nb_wr = nb_wr_reg;
  assign nb_rom_cycle = nb_rom_cycle_reg;
  assign last_sparse_addr = last_sparse_addr_reg;

endmodule // pci_sparse_io_byte_bus_bridge
`default_nettype wire

// ---- pci_sparse_io_byte_bus_bridge_asserts.sv ----
// Port assertions for the byte bus bridge
`timescale 1ns/10ps
`default_nettype none
module pci_sparse_io_byte_bus_bridge_asserts
  import nbus_bridge_pkg::*;
#(parameter int NB_ADDR_W = 17) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_mem_space,
  input wire logic req_pos_claimed,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_byte_en,
  input wire logic [3:0] recovery_field,
  // Answer and byte bus
  input wire logic rsp_valid,
  input wire logic rsp_claimed,
  input wire logic rsp_error,
  input wire logic nb_rd,
  input wire logic nb_wr,
  input wire logic nb_ack,
  input wire logic [NB_ADDR_W-1:0] nb_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shorthands for a taken request and a live strobe
  wire stb = nb_rd | nb_wr;
  wire take = req_valid & req_ready;
  wire inio = !req_mem_space && req_addr < IO_WINDOW_SIZE && !req_pos_claimed;
  sequence done_s; stb && nb_ack; endsequence
  sequence recov_s; !req_ready ##1 req_ready; endsequence
  strobe_hold_a: assert property (stb && !nb_ack |=> stb && $stable(nb_addr)) else $error("strobe left early");
  one_strobe_a: assert property (!(nb_rd && nb_wr)) else $error("both strobes high");
  ack_answer_a: assert property (done_s |=> !stb && rsp_valid && rsp_claimed && !rsp_error) else $error("no answer");
  busy_ready_a: assert property (stb |-> !req_ready) else $error("ready while busy");
  recovery_tick_a: assert property (done_s ##0 recovery_field == 4'h9 |=> recov_s) else $error("bad recovery");
  no_recovery_a: assert property (done_s ##0 !recovery_field[3] |=> req_ready) else $error("extra recovery");
  pos_skip_a: assert property (take && req_pos_claimed |=> rsp_valid && !rsp_claimed && !stb) else $error("claimed");
  bad_enable_a: assert property (take && inio && !$onehot(req_byte_en) |=> rsp_valid && rsp_error && !stb)
    else $error("bad enables passed");
  lane_addr_a: assert property (take && inio && req_byte_en == 4'h1 && req_addr[15:8] != 8'h70
    |=> stb && nb_addr == $past(req_addr[15:2])) else $error("longword address wrong");
endmodule // pci_sparse_io_byte_bus_bridge_asserts
bind pci_sparse_io_byte_bus_bridge pci_sparse_io_byte_bus_bridge_asserts #(.NB_ADDR_W(NB_ADDR_W)) u_chk (.clk, .rst_b,
  .req_valid, .req_ready, .req_mem_space, .req_pos_claimed, .req_addr, .req_byte_en, .recovery_field, .rsp_valid,
  .rsp_claimed, .rsp_error, .nb_rd, .nb_wr, .nb_ack, .nb_addr);
`default_nettype wire

// ---- test_pci_sparse_io_byte_bus_bridge.sv ----
// Self-checking bench for the byte bus bridge
`timescale 1ns/10ps
`default_nettype none
module test_pci_sparse_io_byte_bus_bridge;
  import nbus_bridge_pkg::*;
  logic clk = 0, rst_b = 0, req_valid = 0, req_mem_space = 0, req_write = 0, req_pos_claimed = 0, seen_rom, seen_wr;
  logic [31:0] req_addr = 0, req_wdata = 0;
  logic [3:0] req_byte_en = 0, recovery_field = 4'h9;
  logic [1:0] wait_cycles = 0;
  logic [16:0] seen_addr;
  logic [7:0] seen_wdata;
  logic [7:0] tmem [int];
  wire req_ready, rsp_valid, rsp_claimed, rsp_error, nb_rd, nb_wr, nb_rom_cycle, nb_ack;
  wire [31:0] rsp_rdata, last_sparse_addr;
  wire [16:0] nb_addr;
  wire [7:0] nb_wdata, nb_rdata;
  int n_fail = 0, num_checks = 0, strobes = 0;
  initial forever #4 clk = ~clk;
  pci_sparse_io_byte_bus_bridge DUT (.clk, .rst_b, .req_valid, .req_ready, .req_mem_space, .req_addr, .req_byte_en,
    .req_write, .req_wdata, .req_pos_claimed, .rsp_valid, .rsp_claimed, .rsp_error, .rsp_rdata, .nb_addr, .nb_wdata,
    .nb_rd, .nb_wr, .nb_rom_cycle, .nb_rdata, .nb_ack, .recovery_field, .last_sparse_addr);
  nb_periph_model partner (.clk, .nb_rd, .nb_wr, .nb_addr, .nb_wdata, .wait_cycles, .nb_ack, .nb_rdata);
  // Capture what the bus carried at each acknowledge
  always @(posedge clk) if ((nb_rd || nb_wr) && nb_ack) begin
    strobes++;
    seen_addr = nb_addr;
    seen_wdata = nb_wdata;
    seen_rom = nb_rom_cycle;
    seen_wr = nb_wr;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bound(input int k);
    if (k >= 50) begin n_fail++; print_verdict; end
  endtask
  // One access from the negedge, with the expected outcome worked out first
  task automatic access(input logic mem, input logic [31:0] a, input logic [3:0] be, input logic wr, input logic pos);
    int k, lane, st;
    logic io, claim, err, time_win;
    logic [16:0] na;
    logic [7:0] b;
    req_wdata = $urandom;
    io = !mem && a < IO_WINDOW_SIZE;
    claim = !pos && (io || (mem && a >= ROM_MEM_BASE && a < ROM_MEM_BASE + ROM_MEM_SIZE));
    lane = be[1] ? 1 : be[2] ? 2 : be[3] ? 3 : 0;
    time_win = io && a >= TIME_OF_YEAR_CLOCK_BASE && a < TIME_OF_YEAR_CLOCK_BASE + TIME_OF_YEAR_CLOCK_SIZE;
    err = claim && ($countones(be) != 1 || (io && !time_win && lane != 0));
    // ROM bytes: the enabled lane picks the byte within the aligned longword
    na = mem ? ((17'(a - ROM_MEM_BASE) & 17'h1FFFC) | 17'(lane)) : time_win ? {1'b0, a[15:2], 2'(lane)} : 17'(a[15:2]);
    b = wr ? req_wdata[8*lane+:8] : tmem.exists(na) ? tmem[na] : na[7:0] ^ 8'h5A;
    {req_mem_space, req_addr, req_byte_en, req_write, req_pos_claimed, req_valid} = {mem, a, be, wr, pos, 1'b1};
    st = strobes;
    for (k = 0; k < 50 && !req_ready; k++) @(negedge clk);
    bound(k);
    @(negedge clk) req_valid = 0;
    for (k = 0; k < 50 && !rsp_valid; k++) @(negedge clk);
    bound(k);
    check(rsp_claimed, claim);
    check(rsp_error, err);
    if (claim) check(rsp_rdata, !err && !wr ? 32'(b) << 8 * lane : 32'h0);
    check(strobes - st, claim && !err);
    if (claim && !err) begin
      check(seen_addr, na);
      check(seen_rom, mem);
      if (wr) check(seen_wdata, b);
      check(seen_wr, wr);
      check(req_ready, !(recovery_field[3] && recovery_field[2:0] != 3'h0));
      if (wr) tmem[na] = b;
      if (io) check(last_sparse_addr, SPARSE_IO_BASE + (a[15:0] << SPARSE_SHIFT));
    end
    // Let one edge pass so the next request never re-raises valid in this time step
    @(negedge clk);
  endtask
  // Random mix of regions, lanes, enables, recovery settings and device waits
  initial begin
    int i, kind;
    logic [31:0] a;
    void'($urandom(70));
    repeat (8) @(negedge clk);
    rst_b = 1;
    for (i = 0; i < 150; i++) begin
      kind = $urandom % 6;
      a = kind == 0 ? ($urandom % 64) * 4 : kind == 1 ? TIME_OF_YEAR_CLOCK_BASE + $urandom % 16 : kind == 2 ?
        ROM_MEM_BASE + $urandom % 64 : kind == 5 ? IO_WINDOW_SIZE + $urandom % 8 : $urandom % 256;
      recovery_field = ($urandom % 2) ? 4'h9 : 4'($urandom % 8);
      wait_cycles = 2'($urandom % 3);
      access(kind == 2 || kind == 4, a, ($urandom % 4) ? 4'h1 << a[1:0] : 4'($urandom), 1'($urandom),
        kind != 2 && $urandom % 8 == 0);
    end
    print_verdict;
  end
endmodule // test_pci_sparse_io_byte_bus_bridge
`default_nettype wire
